// ### hw/exception_unit.sv
// Reset control, reset cause record, watchdog and interrupt entry and return sequencer.
// Assumes an AHB-Lite master, a byte memory with combinational read of the registered address,
// and a core that halts while seq_busy is high and holds its register inputs steady.
// Function
// - Any reset loads the PC from the reset vector before the first fetch.
// - Reset sets the global interrupt mask and forces the stack pointer value.
// - Each reset cause except debug-forced has its own status bit.
// - Any reset sets the watchdog enable until software clears it.
// - Any write to the cause status address clears the watchdog counter only.
// - Clock select 0 counts the low-power clock, 1 counts the bus clock.
// - Low-power clock timeout is 32 cycles short, 256 cycles long.
// - Bus clock timeout is 2^13 cycles short, 2^18 cycles long.
// - Out of reset the watchdog uses low-power clock and long timeout.
// - Each option register takes one write after reset; it also clears the watchdog.
// - A watchdog reaching its timeout causes a system reset.
// - The watchdog holds its count in background debug mode.
// - On bus clock the watchdog freezes in stop and resumes after.
// - On low-power clock the watchdog clears on stop entry, restarts from zero.
// - Events set flags; requests need local enable and clear global mask.
// - Entry starts only at an instruction boundary, like the software interrupt.
// - Entry stacks, sets the mask, fetches the top vector, prefetches three bytes.
// - Stacking runs PC low to condition code; SP ends one below it.
// - Return unstacks in reverse order, then prefetches three bytes.
// - The high index register is never stacked or restored.
// - With several pending, the highest-priority source is served first.
//
// Added by the designer: the AHB-Lite slave port and the register offsets.
`timescale 1ns/100ps
module exception_unit
	import exception_unit_pkg::*;
#(
	parameter logic [WDOG_CNT_W-1:0] WDOG_BUS_SHORT = 19'h02000,
	parameter logic [WDOG_CNT_W-1:0] WDOG_BUS_LONG  = 19'h40000
) (
	// Clock and power-on reset
	input  wire logic                 hclk,
	input  wire logic                 hresetn,
	// AHB-Lite slave
	input  wire logic                 hsel,
	input  wire logic [31:0]          haddr,
	input  wire logic [1:0]           htrans,
	input  wire logic                 hwrite,
	input  wire logic [2:0]           hsize,
	input  wire logic [31:0]          hwdata,
	input  wire logic                 hready,
	output logic                      hreadyout,
	output logic                      hresp,
	output logic [31:0]               hrdata,
	// Reset sources and low-power clock (pins and analogue, asynchronous)
	input  wire logic                 pin_reset_n,
	input  wire logic                 low_voltage_reset,
	input  wire logic                 debug_reset,
	input  wire logic                 lpo_clock_in,
	// Core status (bus clock domain)
	input  wire logic                 illegal_opcode_reset,
	input  wire logic                 debug_mode,
	input  wire logic                 stop_mode,
	input  wire logic                 instr_done,
	input  wire logic                 rti_exec,
	input  wire logic                 mask_set,
	input  wire logic                 mask_clear,
	input  wire logic [15:0]          core_next_pc,
	input  wire logic [7:0]           core_a,
	input  wire logic [7:0]           core_x,
	input  wire logic [7:0]           core_ccr,
	// Peripheral interrupt events
	input  wire logic [NUM_SRC-1:0]   irq_event,
	// Core control
	output logic                      system_reset,
	output logic                      seq_busy,
	output logic                      global_mask,
	output logic [15:0]               stack_pointer,
	output logic                      pc_load,
	output logic [15:0]               pc_value,
	output logic                      restore_valid,
	output logic [7:0]                restore_ccr,
	output logic [7:0]                restore_a,
	output logic [7:0]                restore_x,
	output logic                      prefetch_valid,
	output logic [7:0]                prefetch_byte,
	// Memory master
	output logic [15:0]               mem_addr,
	output logic                      mem_read,
	output logic                      mem_write,
	output logic [7:0]                mem_wdata,
	input  wire logic [7:0]           mem_rdata
);

	// ----------------------------------------------------------------
	// Declarations
	// ----------------------------------------------------------------
	logic [1:0]            pin_sync_q, lvr_sync_q, dbg_sync_q, lpo_sync_q;
	logic                  lpo_prev_q;
	logic                  soft_reset;
	logic                  wdog_fire;
	logic [7:0]            cause_q;
	logic [7:0]            opt_one_q, opt_two_q;
	logic                  opt_one_locked_q, opt_two_locked_q;
	logic [WDOG_CNT_W-1:0] wdog_cnt_q, wdog_limit;
	logic                  wdog_tick, wdog_clear;
	logic                  dp_valid_q, dp_write_q;
	logic [7:0]            dp_addr_q;
	logic                  wr_cause, wr_opt_one, wr_opt_two, wr_flags, wr_enable;
	logic [NUM_SRC-1:0]    irq_flag_q, irq_enable_q, pending;
	logic [SRC_W-1:0]      top_src;
	logic                  take_irq;
	seq_state_t            state_q;
	logic [2:0]            step_q;
	logic [15:0]           sp_q, pc_q, vec_addr_q;
	logic                  mask_q;
	logic [7:0]            rd_mux;

	// ----------------------------------------------------------------
	// Input synchronisers
	// ----------------------------------------------------------------
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			pin_sync_q <= 2'h3;
			lvr_sync_q <= 2'h0;
			dbg_sync_q <= 2'h0;
			lpo_sync_q <= 2'h0;
			lpo_prev_q <= 1'b0;
		end else begin
			pin_sync_q <= {pin_sync_q[0], pin_reset_n};
			lvr_sync_q <= {lvr_sync_q[0], low_voltage_reset};
			dbg_sync_q <= {dbg_sync_q[0], debug_reset};
			lpo_sync_q <= {lpo_sync_q[0], lpo_clock_in};
			lpo_prev_q <= lpo_sync_q[1];
		end
	end

	// ----------------------------------------------------------------
	// System reset and cause record
	// ----------------------------------------------------------------
	assign soft_reset = !pin_sync_q[1] | lvr_sync_q[1] | dbg_sync_q[1]
		| illegal_opcode_reset | wdog_fire;
	assign system_reset = soft_reset;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			cause_q <= CAUSE_POR_VALUE;
		end else if (soft_reset) begin
			cause_q                 <= 8'h00;
			cause_q[CAUSE_PIN_BIT]  <= !pin_sync_q[1];
			cause_q[CAUSE_LVR_BIT]  <= lvr_sync_q[1];
			cause_q[CAUSE_ILLEGAL_OPCODE_RESET_BIT] <= illegal_opcode_reset;
			cause_q[CAUSE_WDOG_BIT] <= wdog_fire;
		end
	end

	// ----------------------------------------------------------------
	// AHB-Lite slave, zero wait state
	// ----------------------------------------------------------------
	assign hreadyout = 1'b1;
	assign hresp     = 1'b0;

	always_comb begin
		case (haddr[7:0])
			ADDR_CAUSE:      rd_mux = cause_q;
			ADDR_OPT_ONE:    rd_mux = opt_one_q;
			ADDR_OPT_TWO:    rd_mux = opt_two_q;
			ADDR_IRQ_FLAGS:  rd_mux = irq_flag_q;
			ADDR_IRQ_ENABLE: rd_mux = irq_enable_q;
			default:         rd_mux = 8'h00;
		endcase
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			dp_valid_q <= 1'b0;
			dp_write_q <= 1'b0;
			dp_addr_q  <= 8'h00;
			hrdata     <= 32'h00000000;
		end else if (hready) begin
			dp_valid_q <= hsel & htrans[1];
			dp_write_q <= hwrite;
			dp_addr_q  <= haddr[7:0];
			if (hsel & htrans[1] & !hwrite) begin
				if (haddr[7:0] == ADDR_CORE_STATE) begin
					hrdata <= {12'h000, 3'(state_q), mask_q, sp_q};
				end else begin
					hrdata <= {24'h000000, rd_mux};
				end
			end
		end
	end

	assign wr_cause   = dp_valid_q & dp_write_q & (dp_addr_q == ADDR_CAUSE);
	assign wr_opt_one = dp_valid_q & dp_write_q & (dp_addr_q == ADDR_OPT_ONE);
	assign wr_opt_two = dp_valid_q & dp_write_q & (dp_addr_q == ADDR_OPT_TWO);
	assign wr_flags   = dp_valid_q & dp_write_q & (dp_addr_q == ADDR_IRQ_FLAGS);
	assign wr_enable  = dp_valid_q & dp_write_q & (dp_addr_q == ADDR_IRQ_ENABLE);

	// ----------------------------------------------------------------
	// Write-once option registers
	// ----------------------------------------------------------------
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			opt_one_q        <= OPT_ONE_RESET;
			opt_two_q        <= OPT_TWO_RESET;
			opt_one_locked_q <= 1'b0;
			opt_two_locked_q <= 1'b0;
		end else if (soft_reset) begin
			opt_one_q        <= OPT_ONE_RESET;
			opt_two_q        <= OPT_TWO_RESET;
			opt_one_locked_q <= 1'b0;
			opt_two_locked_q <= 1'b0;
		end else begin
			if (wr_opt_one && !opt_one_locked_q) begin
				opt_one_q        <= hwdata[7:0];
				opt_one_locked_q <= 1'b1;
			end
			if (wr_opt_two && !opt_two_locked_q) begin
				opt_two_q        <= hwdata[7:0];
				opt_two_locked_q <= 1'b1;
			end
		end
	end

	// ----------------------------------------------------------------
	// Watchdog
	// ----------------------------------------------------------------
	always_comb begin
		case ({opt_two_q[WDOG_CLKSEL_BIT], opt_one_q[WDOG_LONG_BIT]})
			2'b00:   wdog_limit = WDOG_LPO_SHORT;
			2'b01:   wdog_limit = WDOG_LPO_LONG;
			2'b10:   wdog_limit = WDOG_BUS_SHORT;
			default: wdog_limit = WDOG_BUS_LONG;
		endcase
	end

	// Bus clock counts every cycle, low-power clock on each rising edge
	assign wdog_tick = opt_two_q[WDOG_CLKSEL_BIT] ? 1'b1 : (lpo_sync_q[1] & !lpo_prev_q);
	assign wdog_clear = wr_cause
		| (wr_opt_one & !opt_one_locked_q) | (wr_opt_two & !opt_two_locked_q);
	assign wdog_fire = opt_one_q[WDOG_EN_BIT] & (wdog_cnt_q >= wdog_limit);

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wdog_cnt_q <= '0;
		end else begin
			if (soft_reset || wdog_clear || !opt_one_q[WDOG_EN_BIT]) begin
				wdog_cnt_q <= '0;
			end else if (stop_mode && !opt_two_q[WDOG_CLKSEL_BIT]) begin
				wdog_cnt_q <= '0;
			end else if (stop_mode || debug_mode) begin
				wdog_cnt_q <= wdog_cnt_q;
			end else if (wdog_tick) begin
				wdog_cnt_q <= wdog_cnt_q + WDOG_ONE;
			end
		end
	end

	// ----------------------------------------------------------------
	// Interrupt flags, enables and priority
	// ----------------------------------------------------------------
	genvar gi;
	generate
		for (gi = 0; gi < NUM_SRC; gi = gi + 1) begin : g_flag
			always_ff @(posedge hclk or negedge hresetn) begin
				if (!hresetn) begin
					irq_flag_q[gi] <= 1'b0;
				end else if (soft_reset) begin
					irq_flag_q[gi] <= 1'b0;
				end else if (irq_event[gi]) begin
					irq_flag_q[gi] <= 1'b1;
				end else if (wr_flags && hwdata[gi]) begin
					irq_flag_q[gi] <= 1'b0;
				end
			end
		end
	endgenerate

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			irq_enable_q <= '0;
		end else if (soft_reset) begin
			irq_enable_q <= '0;
		end else if (wr_enable) begin
			irq_enable_q <= hwdata[NUM_SRC-1:0];
		end
	end

	assign pending = irq_flag_q & irq_enable_q;

	// Highest index wins
	always_comb begin
		top_src = '0;
		for (int i = 0; i < NUM_SRC; i++) begin
			if (pending[i]) begin
				top_src = SRC_W'(i);
			end
		end
	end

	assign take_irq = (state_q == ST_RUN) & instr_done & (|pending) & !mask_q;

	// ----------------------------------------------------------------
	// Entry, return and reset sequencer
	// ----------------------------------------------------------------
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			state_q        <= ST_VECTOR;
			step_q         <= 3'h0;
			sp_q           <= SP_RESET;
			pc_q           <= 16'h0000;
			vec_addr_q     <= RESET_VECTOR;
			mask_q         <= 1'b1;
			mem_addr       <= 16'h0000;
			mem_read       <= 1'b0;
			mem_write      <= 1'b0;
			mem_wdata      <= 8'h00;
			pc_load        <= 1'b0;
			restore_valid  <= 1'b0;
			pc_value       <= 16'h0000;
			restore_ccr    <= 8'h00;
			restore_a      <= 8'h00;
			restore_x      <= 8'h00;
			prefetch_valid <= 1'b0;
			prefetch_byte  <= 8'h00;
		end else if (soft_reset) begin
			state_q        <= ST_VECTOR;
			step_q         <= 3'h0;
			sp_q           <= SP_RESET;
			vec_addr_q     <= RESET_VECTOR;
			mask_q         <= 1'b1;
			mem_read       <= 1'b0;
			mem_write      <= 1'b0;
			pc_load        <= 1'b0;
			restore_valid  <= 1'b0;
			prefetch_valid <= 1'b0;
		end else begin
			mem_read       <= 1'b0;
			mem_write      <= 1'b0;
			pc_load        <= 1'b0;
			restore_valid  <= 1'b0;
			prefetch_valid <= 1'b0;
			step_q         <= step_q + 3'h1;
			case (state_q)
				ST_RUN: begin
					step_q <= 3'h0;
					if (mask_set) begin
						mask_q <= 1'b1;
					end else if (mask_clear) begin
						mask_q <= 1'b0;
					end
					if (take_irq) begin
						state_q    <= ST_STACK;
						vec_addr_q <= SRC_VECTOR_TOP - {12'h000, top_src, 1'b0};
					end else if (rti_exec) begin
						state_q <= ST_UNSTACK;
					end
				end
				ST_STACK: begin
					// PC low, PC high, X, A, CONDITION_CODE_REGISTER; high index never stacked
					mem_write <= 1'b1;
					mem_addr  <= sp_q;
					sp_q      <= sp_q - ONE_16;
					case (step_q)
						3'h0:    mem_wdata <= core_next_pc[7:0];
						3'h1:    mem_wdata <= core_next_pc[15:8];
						3'h2:    mem_wdata <= core_x;
						3'h3:    mem_wdata <= core_a;
						default: begin
							mem_wdata            <= core_ccr;
							mem_wdata[CCR_I_BIT] <= mask_q;
						end
					endcase
					if (step_q == FRAME_LAST) begin
						state_q <= ST_VECTOR;
						step_q  <= 3'h0;
						mask_q  <= 1'b1;
					end
				end
				ST_VECTOR: begin
					if (step_q < VEC_LAST) begin
						mem_read <= 1'b1;
						mem_addr <= vec_addr_q + {13'h0000, step_q};
					end
					if (step_q == 3'h1) begin
						pc_q[15:8] <= mem_rdata;
					end
					if (step_q == VEC_LAST) begin
						pc_q[7:0] <= mem_rdata;
						state_q   <= ST_PREFETCH;
						step_q    <= 3'h0;
					end
				end
				ST_PREFETCH: begin
					if (step_q < PREFETCH_LAST) begin
						mem_read <= 1'b1;
						mem_addr <= pc_q + {13'h0000, step_q};
					end
					if (step_q != 3'h0) begin
						prefetch_valid <= 1'b1;
						prefetch_byte  <= mem_rdata;
					end
					if (step_q == PREFETCH_LAST) begin
						pc_load  <= 1'b1;
						pc_value <= pc_q;
						state_q  <= ST_RUN;
						step_q   <= 3'h0;
					end
				end
				ST_UNSTACK: begin
					// CONDITION_CODE_REGISTER, A, X, PC high, PC low; high index untouched
					if (step_q < UNSTACK_LAST) begin
						mem_read <= 1'b1;
						mem_addr <= sp_q + ONE_16;
						sp_q     <= sp_q + ONE_16;
					end
					case (step_q)
						3'h1: begin
							restore_ccr <= mem_rdata;
							mask_q      <= mem_rdata[CCR_I_BIT];
						end
						3'h2:    restore_a   <= mem_rdata;
						3'h3:    restore_x   <= mem_rdata;
						3'h4:    pc_q[15:8]  <= mem_rdata;
						3'h5:    pc_q[7:0]   <= mem_rdata;
						default: ;
					endcase
					if (step_q == UNSTACK_LAST) begin
						restore_valid <= 1'b1;
						state_q       <= ST_PREFETCH;
						step_q        <= 3'h0;
					end
				end
				default: begin
					state_q <= ST_RUN;
					step_q  <= 3'h0;
				end
			endcase
		end
	end

	assign seq_busy      = (state_q != ST_RUN) | soft_reset;
	assign global_mask   = mask_q;
	assign stack_pointer = sp_q;

endmodule // exception_unit

// ### hw/exception_unit_pkg.sv
// Constants, register map and state codes for the reset, watchdog and interrupt entry unit.
// Assumes a single bus clock domain; shared by the design and the bench.
package exception_unit_pkg;

	// ----------------------------------------------------------------
	// Register map (byte addresses, low address byte decoded)
	// ----------------------------------------------------------------
	localparam logic [7:0]  ADDR_CAUSE      = 8'h00;
	localparam logic [7:0]  ADDR_OPT_ONE    = 8'h04;
	localparam logic [7:0]  ADDR_OPT_TWO    = 8'h08;
	localparam logic [7:0]  ADDR_IRQ_FLAGS  = 8'h0C;
	localparam logic [7:0]  ADDR_IRQ_ENABLE = 8'h10;
	localparam logic [7:0]  ADDR_CORE_STATE = 8'h14;

	// ----------------------------------------------------------------
	// Field positions and reset values
	// ----------------------------------------------------------------
	localparam int          CAUSE_POR_BIT     = 7;
	localparam int          CAUSE_PIN_BIT     = 6;
	localparam int          CAUSE_WDOG_BIT    = 5;
	localparam int          CAUSE_ILLEGAL_OPCODE_RESET_BIT    = 4;
	localparam int          CAUSE_LVR_BIT     = 1;
	localparam int          WDOG_EN_BIT       = 7;
	localparam int          WDOG_LONG_BIT     = 6;
	localparam int          WDOG_CLKSEL_BIT   = 7;
	localparam logic [7:0]  OPT_ONE_RESET     = 8'hC0;
	localparam logic [7:0]  OPT_TWO_RESET     = 8'h00;
	localparam logic [7:0]  CAUSE_POR_VALUE   = 8'h80;
	localparam int          CCR_I_BIT         = 3;
	localparam int          CORE_MASK_BIT     = 16;
	localparam int          CORE_STATE_LSB    = 17;

	// ----------------------------------------------------------------
	// Core addresses and sequence lengths
	// ----------------------------------------------------------------
	localparam logic [15:0] RESET_VECTOR      = 16'hFFFE;
	localparam logic [15:0] SRC_VECTOR_TOP    = 16'hFFFC;
	localparam logic [15:0] SP_RESET          = 16'h00FF;
	localparam logic [15:0] ONE_16            = 16'h0001;
	localparam int          NUM_SRC           = 8;
	localparam int          SRC_W             = 3;
	localparam logic [2:0]  FRAME_LAST        = 3'h4;
	localparam logic [2:0]  VEC_LAST          = 3'h2;
	localparam logic [2:0]  PREFETCH_LAST     = 3'h3;
	localparam logic [2:0]  UNSTACK_LAST      = 3'h5;

	// ----------------------------------------------------------------
	// Watchdog timing
	// ----------------------------------------------------------------
	localparam int          LPO_PERIOD_US     = 1000;
	localparam int          WDOG_SHORT_US     = 32000;
	localparam int          WDOG_LONG_US      = 256000;
	localparam int          WDOG_CNT_W        = 19;
	localparam logic [WDOG_CNT_W-1:0] WDOG_LPO_SHORT =
		WDOG_CNT_W'(WDOG_SHORT_US / LPO_PERIOD_US);
	localparam logic [WDOG_CNT_W-1:0] WDOG_LPO_LONG  =
		WDOG_CNT_W'(WDOG_LONG_US / LPO_PERIOD_US);
	localparam logic [WDOG_CNT_W-1:0] WDOG_ONE       = 19'h00001;

	// ----------------------------------------------------------------
	// Sequencer states
	// ----------------------------------------------------------------
	typedef enum logic [2:0] {
		ST_RUN      = 3'b000,
		ST_VECTOR   = 3'b001,
		ST_PREFETCH = 3'b010,
		ST_STACK    = 3'b011,
		ST_UNSTACK  = 3'b100
	} seq_state_t;

endpackage

// ### sim/exception_unit_properties.sv
// Concurrent checks on the exception unit ports.
// Assumes one hclk domain; bound from the bench top file.
`timescale 1ns/100ps
module exception_unit_properties
	import exception_unit_pkg::*;
(
	// Clock and reset
	input wire logic        hclk,
	input wire logic        hresetn,
	// Observed outputs and core strobe
	input wire logic        instr_done,
	input wire logic        system_reset,
	input wire logic        global_mask,
	input wire logic [15:0] stack_pointer,
	input wire logic        pc_load,
	input wire logic        restore_valid,
	input wire logic        prefetch_valid,
	input wire logic [15:0] mem_addr,
	input wire logic        mem_read,
	input wire logic        mem_write
);
	// ----------------------------------------------------------------
	// Sequences and properties
	// ----------------------------------------------------------------
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);
	sequence stack_s; mem_write [*5]; endsequence
	sequence vector_s; mem_read [*2]; endsequence
	sequence fill_s; mem_read [*3]; endsequence
	sequence refill_s; prefetch_valid [*3]; endsequence

	a_reset_state: assert property (system_reset ##1 system_reset |->
		global_mask && stack_pointer == SP_RESET) else $error("reset state wrong");
	a_reset_vector: assert property ($fell(system_reset) |->
		##[0:8] (mem_read && mem_addr == RESET_VECTOR)) else $error("no vector read");
	a_entry_order: assert property ($rose(mem_write) |->
		stack_s ##1 vector_s ##2 fill_s ##1 pc_load) else $error("entry order wrong");
	a_stack_down: assert property (mem_write && $past(mem_write) |->
		mem_addr == $past(mem_addr) - ONE_16) else $error("stack not descending");
	a_entry_boundary: assert property ($rose(mem_write) |-> $past(instr_done, 2))
		else $error("entry off boundary");
	a_entry_masked: assert property ($rose(mem_write) |-> !$past(global_mask))
		else $error("entry while masked");
	a_rti_refill: assert property ($rose(restore_valid) |->
		##[1:4] refill_s ##[0:2] pc_load) else $error("return refill wrong");
	a_unstack_reads: assert property ($rose(restore_valid) |-> $past(mem_read))
		else $error("restore without reads");
endmodule // exception_unit_properties

// ### sim/exception_memory_model.sv
// Byte memory on the far side: stack RAM and vector image.
// Assumes registered mem_addr; read data is combinational.
`timescale 1ns/100ps
module exception_memory_model (
	// Clock
	input wire logic        hclk,
	// Memory port
	input wire logic [15:0] mem_addr,
	input wire logic        mem_read,
	input wire logic        mem_write,
	input wire logic [7:0]  mem_wdata,
	output logic [7:0]      mem_rdata
);
	// ----------------------------------------------------------------
	// Storage, image and read path
	// ----------------------------------------------------------------
	logic [7:0] mem [0:65535];
	logic [7:0] last_q;
	initial begin
		foreach (mem[i]) mem[i] = 8'h00;
		mem[16'hFFFE] = 8'h12;
		mem[16'hFFFF] = 8'h34;
		mem[16'hFFEE] = 8'h20;
		mem[16'hFFFC] = 8'h30;
		last_q = 8'h00;
	end
	always @(posedge hclk) begin
		if (mem_write) mem[mem_addr] <= mem_wdata;
		if (mem_read) last_q <= mem[mem_addr];
	end
	// Not reading: show the inverse of the last byte
	assign mem_rdata = mem_read ? mem[mem_addr] : ~last_q;
endmodule // exception_memory_model

// ### sim/exception_unit_tb.sv
// Self-checking bench for the exception unit.
// Assumes the memory model and checker files are compiled first.
`timescale 1ns/100ps
module exception_unit_tb;
	import exception_unit_pkg::*;
	// ----------------------------------------------------------------
	// Signals
	// ----------------------------------------------------------------
	logic        hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp, rst_seen;
	logic [31:0] haddr, hwdata, hrdata, rd;
	logic [1:0]  htrans;
	logic [2:0]  hsize;
	logic        pin_reset_n, low_voltage_reset, debug_reset, lpo_clock_in;
	logic        illegal_opcode_reset, debug_mode, stop_mode, instr_done, rti_exec;
	logic        mask_set, mask_clear, system_reset, seq_busy, global_mask, pc_load;
	logic        restore_valid, prefetch_valid, mem_read, mem_write;
	logic [15:0] core_next_pc, stack_pointer, pc_value, mem_addr;
	logic [7:0]  core_a, core_x, core_ccr, restore_ccr, restore_a, restore_x;
	logic [7:0]  prefetch_byte, mem_wdata, mem_rdata;
	logic [NUM_SRC-1:0] irq_event;
	int          errors, n_compared, cyc, n_wr;

	assign hready = hreadyout;
	exception_unit #(.WDOG_BUS_SHORT(19'h00010), .WDOG_BUS_LONG(19'h00040)) dut (.*);
	exception_memory_model u_mem (.hclk(hclk), .mem_addr(mem_addr), .mem_read(mem_read),
		.mem_write(mem_write), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata));

	always #12.5 hclk = ~hclk;
	always @(negedge hclk) begin
		if (mem_write === 1'b1) n_wr++;
		if (system_reset === 1'b1 && hresetn) rst_seen = 1'b1;
	end
	always @(posedge hclk) begin
		cyc <= cyc + 1;
		lpo_clock_in <= cyc[4];
		if (cyc == 12000) begin
			errors++;
			complete_run;
		end
	end
	// ----------------------------------------------------------------
	// Tasks
	// ----------------------------------------------------------------
	task check(input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			errors++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
		hsel <= 1'b1;
		htrans <= 2'b10;
		hwrite <= w;
		haddr <= {24'h000000, a};
		do @(posedge hclk); while (hreadyout !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'b00;
		hwdata <= d;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		rd = hrdata;
	endtask
	task rdchk(input logic [7:0] a, input logic [31:0] exp);
		ahb(1'b0, a, 32'h00000000);
		check(rd, exp);
	endtask
	task tick(input int n);
		repeat (n) @(posedge hclk);
	endtask
	task idle;
		do @(posedge hclk); while (seq_busy !== 1'b0);
	endtask
	task wpc;
		do @(posedge hclk); while (pc_load !== 1'b1);
	endtask
	task go_irq(input logic clr);
		mask_clear <= clr;
		tick(1);
		mask_clear <= 1'b0;
		instr_done <= 1'b1;
		tick(1);
		instr_done <= 1'b0;
	endtask
	task complete_run;
		$display("compared %0d mismatches %0d", n_compared, errors);
		if (errors == 0 && n_compared > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask
	// ----------------------------------------------------------------
	// Sequence
	// ----------------------------------------------------------------
	initial begin
		{hclk, hresetn, hsel, hwrite, htrans, haddr, hwdata, rst_seen} = '0;
		{low_voltage_reset, debug_reset, illegal_opcode_reset, mask_set} = '0;
		{debug_mode, stop_mode, instr_done, rti_exec, mask_clear, irq_event} = '0;
		{errors, n_compared, cyc, n_wr} = '0;
		{hsize, pin_reset_n, lpo_clock_in} = 5'b01010;
		{core_next_pc, core_a, core_x, core_ccr} = 40'hABCD112260;
		tick(20);
		hresetn <= 1'b1;
		wpc;
		check(pc_value, 16'h1234);
		idle;
		rdchk(ADDR_CAUSE, CAUSE_POR_VALUE);
		rdchk(ADDR_OPT_ONE, OPT_ONE_RESET);
		rdchk(ADDR_OPT_TWO, OPT_TWO_RESET);
		rdchk(ADDR_CORE_STATE, 32'h000100FF);
		pin_reset_n <= 1'b0;
		tick(4);
		pin_reset_n <= 1'b1;
		wpc;
		idle;
		rdchk(ADDR_CAUSE, 32'h00000040);
		ahb(1'b1, ADDR_OPT_TWO, 32'h00000080);
		ahb(1'b1, ADDR_OPT_TWO, 32'h00000000);
		rdchk(ADDR_OPT_TWO, 32'h00000080);
		ahb(1'b1, ADDR_OPT_ONE, 32'h00000080);
		ahb(1'b1, ADDR_OPT_ONE, 32'h000000C0);
		rdchk(ADDR_OPT_ONE, 32'h00000080);
		rst_seen = 1'b0;
		repeat (10) ahb(1'b1, ADDR_CAUSE, 32'h000000FF);
		rdchk(ADDR_CAUSE, 32'h00000040);
		stop_mode <= 1'b1;
		tick(30);
		stop_mode <= 1'b0;
		tick(10);
		check(rst_seen, 1'b0);
		tick(5);
		check(rst_seen, 1'b1);
		wpc;
		check(pc_value, 16'h1234);
		idle;
		rdchk(ADDR_CAUSE, 32'h00000020);
		rdchk(ADDR_OPT_ONE, OPT_ONE_RESET);
		ahb(1'b1, ADDR_OPT_ONE, 32'h00000080);
		ahb(1'b1, ADDR_OPT_TWO, 32'h00000000);
		tick(600);
		stop_mode <= 1'b1;
		rst_seen = 1'b0;
		tick(1200);
		stop_mode <= 1'b0;
		debug_mode <= 1'b1;
		tick(1200);
		debug_mode <= 1'b0;
		tick(900);
		check(rst_seen, 1'b0);
		repeat (300) if (rst_seen !== 1'b1) @(posedge hclk);
		check(rst_seen, 1'b1);
		wpc;
		idle;
		low_voltage_reset <= 1'b1;
		debug_reset <= 1'b1;
		illegal_opcode_reset <= 1'b1;
		tick(4);
		low_voltage_reset <= 1'b0;
		debug_reset <= 1'b0;
		tick(2);
		illegal_opcode_reset <= 1'b0;
		wpc;
		idle;
		rdchk(ADDR_CAUSE, 32'h00000012);
		ahb(1'b1, ADDR_OPT_ONE, 32'h00000000);
		ahb(1'b1, ADDR_IRQ_ENABLE, 32'h00000081);
		irq_event <= 8'h81;
		tick(1);
		irq_event <= 8'h00;
		go_irq(1'b0);
		tick(4);
		check(n_wr, 0);
		rdchk(ADDR_IRQ_FLAGS, 32'h00000081);
		go_irq(1'b1);
		wpc;
		check(pc_value, 16'h2000);
		check(u_mem.mem[16'h00FF], 8'hCD);
		check(u_mem.mem[16'h00FE], 8'hAB);
		check(u_mem.mem[16'h00FD], 8'h22);
		check(u_mem.mem[16'h00FC], 8'h11);
		check(u_mem.mem[16'h00FB], 8'h60);
		idle;
		rdchk(ADDR_CORE_STATE, 32'h000100FA);
		ahb(1'b1, ADDR_IRQ_FLAGS, 32'h00000080);
		rdchk(ADDR_IRQ_FLAGS, 32'h00000001);
		rti_exec <= 1'b1;
		tick(1);
		rti_exec <= 1'b0;
		do @(posedge hclk); while (restore_valid !== 1'b1);
		check({restore_ccr, restore_a, restore_x}, 24'h601122);
		wpc;
		check(pc_value, 16'hABCD);
		idle;
		go_irq(1'b1);
		wpc;
		check(pc_value, 16'h3000);
		complete_run;
	end
endmodule // exception_unit_tb

bind exception_unit exception_unit_properties u_props (.*);
